// ### logic/vcx_consts.svh
// constants of the divider planner and its synthesizer end
// Function
// - output is vco over hs times ls
// - vco is xtal times feedback_divider, tuned by vc
// - vco between 10.8 GHz and grade maximum
// - planning assumes 152.6 MHz crystal
// - output frequency within grade range
// - divider values are unsigned and positive
// - hs divider keeps 50% duty, odd ratios
// - ls divider divides by powers of two
// - host reloads full scale gain after changes
// - vc adc rate derived from vco
// - gain is rounded 128*80e6 over adc rate
// - adc rate factor from feedback_divider integer part
// - feedback_divider integer part by truncation
// - estimate total divide from minimum vco
// - pick smallest ls ratio that fits
// - nearest valid hs keeping vco above minimum
// - feedback_divider is vco over crystal at mid
// - feedback_divider is 11.32 unsigned fixed point
// - hs above 33 must be even
// - ls exponent 5 to 7 gives 32
`ifndef VCX_CONSTS_SVH
`define VCX_CONSTS_SVH
// ----------------------------------------------------------------
// frequency plan, in hertz
// ----------------------------------------------------------------
`define VCX_XTAL_HZ 34'd152600000
`define VCX_VCO_MIN_HZ 34'd10800000000
`define VCX_VCO_MAX_A 34'd13122222022
`define VCX_VCO_MAX_B 34'd12511886114
`define VCX_VCO_MAX_CD 34'd12206718160
`define VCX_FOUT_MIN 32'd200000
`define VCX_FOUT_MAX_A 32'd3000000000
`define VCX_FOUT_MAX_B 32'd1500000000
`define VCX_FOUT_MAX_C 32'd800000000
`define VCX_FOUT_MAX_D 32'd325000000
`define VCX_GAIN_NUM (37'd128 * 37'd80000000 * 37'd8)
// ----------------------------------------------------------------
// divider limits
// ----------------------------------------------------------------
`define VCX_HS_MIN 11'h004
`define VCX_HS_ODD_MAX 11'h021
`define VCX_HS_MAX 11'h07FE
`define VCX_LS_EXP_MAX 3'h5
`define VCX_FX_EDGE0 11'h048
`define VCX_FX_EDGE1 11'h04F
`define VCX_FX_EDGE2 11'h056
`define VCX_FX_F0 5'h10
`define VCX_FX_F1 5'h12
`define VCX_FX_F2 5'h14
`define VCX_FX_F3 5'h16
`define VCX_DIV_STEPS 7'h42
// ----------------------------------------------------------------
// synthesizer model
// ----------------------------------------------------------------
`define VCX_TICK_SHIFT 16
`define VCX_VDD_MV 3300
`define VCX_PPM_RECIP 23'd1125900
`define VCX_FB_RST 43'h048_0000_0000
`define VCX_HS_RST 11'h046
`define VCX_LS_RST 3'h0
`define VCX_GAIN_RST 8'h80
`define VCX_KV_RST 16'h0000
// ----------------------------------------------------------------
// host register byte offsets
// ----------------------------------------------------------------
`define VCX_REG_CTRL 8'h00
`define VCX_REG_FOUT 8'h04
`define VCX_REG_KV 8'h08
`define VCX_REG_STATUS 8'h0C
`define VCX_REG_HSLS 8'h10
`define VCX_REG_FBLO 8'h14
`define VCX_REG_FBHI 8'h18
`define VCX_REG_GAIN 8'h1C
`endif

// ### logic/vcx_pkg.sv
// shared types and the adc rate factor lookup
`include "vcx_consts.svh"
package vcx_pkg;
	typedef logic [42:0] vcx_feedback_divider_t;
	typedef enum logic [1:0] {
		GRADE_A = 2'h0,
		GRADE_B = 2'h1,
		GRADE_C = 2'h2,
		GRADE_D = 2'h3
	} vcx_grade_e;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_RANGE = 4'h1,
		S_DIV = 4'h2,
		S_MT = 4'h3,
		S_LSSEL = 4'h4,
		S_HSSEL = 4'h5,
		S_VCO = 4'h6,
		S_FB = 4'h7,
		S_GAIN = 4'h8,
		S_LOAD = 4'h9,
		S_WACK = 4'hA
	} vcx_state_e;

	function automatic logic [4:0] vcx_adc_factor(input logic [10:0] fb_int);
		if (fb_int < `VCX_FX_EDGE0)
			vcx_adc_factor = `VCX_FX_F0;
		else if (fb_int < `VCX_FX_EDGE1)
			vcx_adc_factor = `VCX_FX_F1;
		else if (fb_int < `VCX_FX_EDGE2)
			vcx_adc_factor = `VCX_FX_F2;
		else
			vcx_adc_factor = `VCX_FX_F3;
	endfunction
endpackage

// ### logic/vcx_link_if.sv
// settings link between the planner host and the synthesizer end
interface vcx_link_if;
	logic load;
	vcx_pkg::vcx_feedback_divider_t feedback_divider;
	logic [10:0] high_speed_output_divider;
	logic [2:0] low_speed_power2_divider;
	logic [7:0] vc_adc_full_scale_gain;
	logic [15:0] tuning_gain_ppm_per_volt;
	logic load_ack;
	modport dev (
		input load,
		input feedback_divider,
		input high_speed_output_divider,
		input low_speed_power2_divider,
		input vc_adc_full_scale_gain,
		input tuning_gain_ppm_per_volt,
		output load_ack
	);
	modport host (
		output load,
		output feedback_divider,
		output high_speed_output_divider,
		output low_speed_power2_divider,
		output vc_adc_full_scale_gain,
		output tuning_gain_ppm_per_volt,
		input load_ack
	);
endinterface

// ### logic/vcx_synth_dev.sv
// synthesizer end: holds divider settings, tunes and divides the vco
`include "vcx_consts.svh"
module vcx_synth_dev #(
	parameter int TICK_SHIFT = `VCX_TICK_SHIFT,
	parameter int VDD_MV = `VCX_VDD_MV
) (
	input wire logic pclk,
	input wire logic presetn,
	vcx_link_if.dev link,
	input wire logic [11:0] control_voltage_input,
	output logic clk_out
);
	import vcx_pkg::*;

	if (TICK_SHIFT < 12 || TICK_SHIFT > 40 || VDD_MV < 2 || VDD_MV > 8190)
	begin : g_chk
		$error("vcx_synth_dev parameter out of range");
	end

	// ----------------------------------------------------------------
	// settings
	// ----------------------------------------------------------------
	vcx_feedback_divider_t fb_reg;
	logic [10:0] hs_reg;
	logic [2:0] ls_reg;
	logic [7:0] gain_reg;
	logic [15:0] kv_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fb_reg <= `VCX_FB_RST;
			hs_reg <= `VCX_HS_RST;
			ls_reg <= `VCX_LS_RST;
			gain_reg <= `VCX_GAIN_RST;
			kv_reg <= `VCX_KV_RST;
			link.load_ack <= 1'b0;
		end
		else
		begin
			link.load_ack <= link.load;
			if (link.load)
			begin
				fb_reg <= link.feedback_divider;
				hs_reg <= link.high_speed_output_divider;
				ls_reg <= link.low_speed_power2_divider;
				gain_reg <= link.vc_adc_full_scale_gain;
				kv_reg <= link.tuning_gain_ppm_per_volt;
			end
		end
	end

	// ----------------------------------------------------------------
	// control voltage adc, paced by the vco
	// ----------------------------------------------------------------
	logic [8:0] adc_cnt_reg;
	logic [11:0] vc_reg;
	logic [31:0] acc_reg;
	logic [31:0] incr_reg;
	wire [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, incr_reg};
	// one carry per vco half period, so odd hs ratios still split evenly
	wire half_tick = acc_sum[32];
	wire [4:0] adc_factor = vcx_adc_factor(fb_reg[42:32]);
	wire [8:0] adc_last = 9'({adc_factor, 4'h0} - 9'h001);
	wire adc_wrap = adc_cnt_reg >= adc_last;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_cnt_reg <= 9'h000;
			vc_reg <= 12'(VDD_MV / 2);
		end
		else if (half_tick)
		begin
			adc_cnt_reg <= adc_wrap ? 9'h000 : adc_cnt_reg + 9'h001;
			if (adc_wrap)
				vc_reg <= control_voltage_input;
		end
	end

	// ----------------------------------------------------------------
	// tuning: feedback_divider * (1 + (vc - vdd/2) * kv), pipelined
	// ----------------------------------------------------------------
	wire signed [13:0] vc_off = $signed({2'b00, vc_reg}) - $signed(14'(VDD_MV / 2));
	wire signed [22:0] vc_prod = 23'(vc_off) * 23'($signed({1'b0, gain_reg}));
	wire signed [15:0] vc_sc = vc_prod[22:7];
	logic signed [32:0] p1_reg;
	logic signed [76:0] p2_reg;
	logic signed [44:0] delta_reg;
	// millivolts times ppm scaled by 2^50 / 1e9
	wire signed [99:0] p3 = 100'(p2_reg) * 100'($signed({1'b0, `VCX_PPM_RECIP}));
	wire signed [44:0] adj = $signed({2'b00, fb_reg}) + delta_reg;
	wire [43:0] adj_pos = adj[44] ? 44'h000_0000_0000 : adj[43:0];
	wire [31:0] incr_next = 32'(adj_pos >> TICK_SHIFT);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			p1_reg <= 33'sh0_0000_0000;
			p2_reg <= '0;
			delta_reg <= '0;
			incr_reg <= 32'h0000_0000;
			acc_reg <= 32'h0000_0000;
		end
		else
		begin
			p1_reg <= 33'(vc_sc) * 33'($signed({1'b0, kv_reg}));
			p2_reg <= 77'($signed({1'b0, fb_reg})) * 77'(p1_reg);
			delta_reg <= p3[94:50];
			incr_reg <= incr_next;
			acc_reg <= acc_sum[31:0];
		end
	end

	// ----------------------------------------------------------------
	// output dividers
	// ----------------------------------------------------------------
	logic [10:0] hs_cnt_reg;
	logic hs_out_reg;
	logic [4:0] ls_cnt_reg;
	wire [10:0] hs_eff = (hs_reg == 11'h000) ? 11'h001 : hs_reg;
	wire hs_wrap = hs_cnt_reg >= 11'(hs_eff - 11'h001);
	wire [2:0] ls_exp = (ls_reg > `VCX_LS_EXP_MAX) ? `VCX_LS_EXP_MAX : ls_reg;
	wire [5:0] out_sel = {ls_cnt_reg, hs_out_reg};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hs_cnt_reg <= 11'h000;
			hs_out_reg <= 1'b0;
			ls_cnt_reg <= 5'h00;
			clk_out <= 1'b0;
		end
		else
		begin
			if (half_tick)
			begin
				// toggle every hs half periods: period hs, duty 50% also for odd
				hs_cnt_reg <= hs_wrap ? 11'h000 : hs_cnt_reg + 11'h001;
				if (hs_wrap)
					hs_out_reg <= ~hs_out_reg;
				if (hs_wrap && !hs_out_reg)
					ls_cnt_reg <= ls_cnt_reg + 5'h01;
			end
			clk_out <= out_sel[ls_exp];
		end
	end
endmodule // vcx_synth_dev

// ### logic/vcx_planner_host.sv
// planner end: apb slave that derives and loads divider settings
`include "vcx_consts.svh"
module vcx_planner_host #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	vcx_link_if.host link
);
	import vcx_pkg::*;

	if (ADDR_W < 5 || ADDR_W > 32)
	begin : g_chk
		$error("vcx_planner_host address width out of range");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	vcx_state_e state_reg;
	vcx_state_e ret_reg;
	vcx_grade_e grade_reg;
	logic [31:0] fout_reg;
	logic [15:0] kv_reg;
	logic busy_reg;
	logic done_reg;
	logic fail_reg;
	logic [10:0] hs_reg;
	logic [2:0] exp_reg;
	logic [15:0] mt_reg;
	logic [33:0] fvco_reg;
	vcx_feedback_divider_t fb_reg;
	logic [4:0] factor_reg;
	logic [7:0] gain_reg;
	logic load_reg;
	logic [65:0] num_reg;
	logic [33:0] den_reg;
	logic [34:0] rem_reg;
	logic [6:0] cnt_reg;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire [7:0] addr8 = 8'(paddr);
	wire high_zero = (ADDR_W <= 8) ? 1'b1 : ((paddr >> 8) == '0);
	wire setup = psel && !penable;
	wire wr_go = psel && penable && pready && pwrite;
	wire hit_ctrl = high_zero && addr8 == `VCX_REG_CTRL;
	wire hit_fout = high_zero && addr8 == `VCX_REG_FOUT;
	wire hit_kv = high_zero && addr8 == `VCX_REG_KV;
	wire hit_stat = high_zero && addr8 == `VCX_REG_STATUS;
	wire hit_hsls = high_zero && addr8 == `VCX_REG_HSLS;
	wire hit_fblo = high_zero && addr8 == `VCX_REG_FBLO;
	wire hit_fbhi = high_zero && addr8 == `VCX_REG_FBHI;
	wire hit_gain = high_zero && addr8 == `VCX_REG_GAIN;
	wire hit_any = hit_ctrl | hit_fout | hit_kv | hit_stat | hit_hsls | hit_fblo |
		hit_fbhi | hit_gain;
	// a start while busy is dropped so results are never mixed
	wire start_go = wr_go && hit_ctrl && pwdata[0] && !busy_reg;
	wire [31:0] rd_mux =
		hit_ctrl ? {29'h0000_0000, grade_reg, 1'b0} :
		hit_fout ? fout_reg :
		hit_kv ? {16'h0000, kv_reg} :
		hit_stat ? {29'h0000_0000, fail_reg, done_reg, busy_reg} :
		hit_hsls ? {17'h0_0000, exp_reg, 1'b0, hs_reg} :
		hit_fblo ? fb_reg[31:0] :
		hit_fbhi ? {21'h00_0000, fb_reg[42:32]} :
		hit_gain ? {19'h0_0000, factor_reg, gain_reg} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			grade_reg <= GRADE_A;
			fout_reg <= 32'h0000_0000;
			kv_reg <= `VCX_KV_RST;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !hit_any;
			if (setup)
				prdata <= rd_mux;
			if (wr_go && hit_ctrl && !busy_reg)
				grade_reg <= vcx_grade_e'(pwdata[2:1]);
			if (wr_go && hit_fout && !busy_reg)
				fout_reg <= pwdata;
			if (wr_go && hit_kv && !busy_reg)
				kv_reg <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// grade limits and datapath
	// ----------------------------------------------------------------
	wire [31:0] fout_max = (grade_reg == GRADE_A) ? `VCX_FOUT_MAX_A :
		(grade_reg == GRADE_B) ? `VCX_FOUT_MAX_B :
		(grade_reg == GRADE_C) ? `VCX_FOUT_MAX_C : `VCX_FOUT_MAX_D;
	wire [33:0] vco_max = (grade_reg == GRADE_A) ? `VCX_VCO_MAX_A :
		(grade_reg == GRADE_B) ? `VCX_VCO_MAX_B : `VCX_VCO_MAX_CD;
	wire fout_bad = fout_reg < `VCX_FOUT_MIN || fout_reg > fout_max;

	// restoring divider, one quotient bit per cycle into num_reg
	wire [34:0] rem_sh = {rem_reg[33:0], num_reg[65]};
	wire rem_ge = rem_sh >= {1'b0, den_reg};
	wire [34:0] rem_new = rem_ge ? rem_sh - {1'b0, den_reg} : rem_sh;

	wire [16:0] ls_round = 17'(({1'b0, mt_reg} + (17'h0_0001 << exp_reg)) - 17'h0_0001);
	wire [16:0] hs_try = ls_round >> exp_reg;
	wire [47:0] fvco_prod = 48'(fout_reg) * 48'(hs_reg);
	wire [47:0] fvco_calc = fvco_prod << exp_reg;
	wire [4:0] factor_new = vcx_adc_factor(num_reg[42:32]);
	wire [65:0] gain_num = 66'(`VCX_GAIN_NUM) * 66'(factor_new) + 66'(fvco_reg >> 1);

	// ----------------------------------------------------------------
	// planning sequence
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= S_IDLE;
			ret_reg <= S_IDLE;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			hs_reg <= `VCX_HS_RST;
			exp_reg <= `VCX_LS_RST;
			mt_reg <= 16'h0000;
			fvco_reg <= 34'h0_0000_0000;
			fb_reg <= `VCX_FB_RST;
			factor_reg <= `VCX_FX_F0;
			gain_reg <= `VCX_GAIN_RST;
			load_reg <= 1'b0;
			num_reg <= '0;
			den_reg <= 34'h0_0000_0001;
			rem_reg <= '0;
			cnt_reg <= 7'h00;
		end
		else
		begin
			load_reg <= 1'b0;
			case (state_reg)
				S_IDLE:
					if (start_go)
					begin
						busy_reg <= 1'b1;
						done_reg <= 1'b0;
						fail_reg <= 1'b0;
						state_reg <= S_RANGE;
					end
				S_RANGE:
					if (fout_bad)
					begin
						fail_reg <= 1'b1;
						busy_reg <= 1'b0;
						state_reg <= S_IDLE;
					end
					else
					begin
						num_reg <= 66'(`VCX_VCO_MIN_HZ);
						den_reg <= {2'b00, fout_reg};
						rem_reg <= '0;
						cnt_reg <= `VCX_DIV_STEPS;
						ret_reg <= S_MT;
						state_reg <= S_DIV;
					end
				S_DIV:
				begin
					num_reg <= {num_reg[64:0], rem_ge};
					rem_reg <= rem_new;
					cnt_reg <= cnt_reg - 7'h01;
					if (cnt_reg == 7'h01)
						state_reg <= ret_reg;
				end
				S_MT:
				begin
					// ceiling keeps the vco at or above its minimum
					mt_reg <= num_reg[15:0] + {15'h0000, rem_reg != '0};
					exp_reg <= 3'h0;
					state_reg <= S_LSSEL;
				end
				S_LSSEL:
					if (hs_try <= {6'h00, `VCX_HS_MAX})
					begin
						hs_reg <= hs_try[10:0];
						state_reg <= S_HSSEL;
					end
					else if (exp_reg == `VCX_LS_EXP_MAX)
					begin
						fail_reg <= 1'b1;
						busy_reg <= 1'b0;
						state_reg <= S_IDLE;
					end
					else
						exp_reg <= exp_reg + 3'h1;
				S_HSSEL:
				begin
					if (hs_reg < `VCX_HS_MIN)
						hs_reg <= `VCX_HS_MIN;
					else if (hs_reg > `VCX_HS_ODD_MAX && hs_reg[0])
						hs_reg <= hs_reg + 11'h001;
					state_reg <= S_VCO;
				end
				S_VCO:
					if (fvco_calc > {14'h0000, vco_max} || fvco_calc < 48'(`VCX_VCO_MIN_HZ))
					begin
						fail_reg <= 1'b1;
						busy_reg <= 1'b0;
						state_reg <= S_IDLE;
					end
					else
					begin
						fvco_reg <= fvco_calc[33:0];
						num_reg <= {fvco_calc[33:0], 32'h0000_0000};
						den_reg <= `VCX_XTAL_HZ;
						rem_reg <= '0;
						cnt_reg <= `VCX_DIV_STEPS;
						ret_reg <= S_FB;
						state_reg <= S_DIV;
					end
				S_FB:
				begin
					fb_reg <= num_reg[42:0];
					factor_reg <= factor_new;
					num_reg <= gain_num;
					den_reg <= fvco_reg;
					rem_reg <= '0;
					cnt_reg <= `VCX_DIV_STEPS;
					ret_reg <= S_GAIN;
					state_reg <= S_DIV;
				end
				S_GAIN:
				begin
					gain_reg <= (num_reg[65:8] != '0) ? 8'hFF : num_reg[7:0];
					state_reg <= S_LOAD;
				end
				S_LOAD:
				begin
					load_reg <= 1'b1;
					state_reg <= S_WACK;
				end
				S_WACK:
					if (link.load_ack)
					begin
						done_reg <= 1'b1;
						busy_reg <= 1'b0;
						state_reg <= S_IDLE;
					end
				default:
					state_reg <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// link drive
	// ----------------------------------------------------------------
	assign link.load = load_reg;
	assign link.feedback_divider = fb_reg;
	assign link.high_speed_output_divider = hs_reg;
	assign link.low_speed_power2_divider = exp_reg;
	assign link.vc_adc_full_scale_gain = gain_reg;
	assign link.tuning_gain_ppm_per_volt = kv_reg;
endmodule // vcx_planner_host

// ### verification/vcx_link_assertions.sv
// concurrent checks on the settings link between planner and synthesizer
module vcx_link_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire vcx_pkg::vcx_feedback_divider_t feedback_divider,
	input wire logic [10:0] high_speed_output_divider,
	input wire logic [2:0] low_speed_power2_divider,
	input wire logic [7:0] vc_adc_full_scale_gain,
	input wire logic [15:0] tuning_gain_ppm_per_volt,
	input wire logic load_ack
);
	import vcx_pkg::*;
	// ----------------------------------------------------------------
	// handshake and settings
	// ----------------------------------------------------------------
	// settings only mean something while load is high, so every value check is gated by it
	wire [10:0] fb_int = feedback_divider[42:32];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence settings_loaded;
		load;
	endsequence
	sequence acked_next;
		##1 load_ack;
	endsequence
	ack_follow_a: assert property (settings_loaded |-> acked_next)
		else $error("load not acknowledged next cycle");
	ack_cause_a: assert property (load_ack |-> $past(load))
		else $error("ack without load");
	ack_pulse_a: assert property (load_ack && !load |=> !load_ack)
		else $error("ack longer than one cycle");
	hs_range_a: assert property (load |-> high_speed_output_divider inside {[4:2046]})
		else $error("high speed ratio out of range");
	hs_even_a: assert property (load && high_speed_output_divider > 11'h021
		|-> !high_speed_output_divider[0])
		else $error("odd high speed ratio above 33");
	ls_exp_a: assert property (load |-> low_speed_power2_divider <= 3'h5)
		else $error("low speed exponent above 5");
	fb_int_a: assert property (settings_loaded |-> fb_int inside {[70:85]})
		else $error("feedback integer outside vco range");
	gain_low_a: assert property (load && fb_int < 11'h048
		|-> vc_adc_full_scale_gain inside {[119:121]})
		else $error("gain wrong for factor 16");
	gain_mid_a: assert property (load && fb_int inside {[72:78]}
		|-> vc_adc_full_scale_gain inside {[122:134]})
		else $error("gain wrong for factor 18");
endmodule // vcx_link_assertions

// ### verification/vcxo_divider_and_gain_planner_tb_top.sv
// bench: planner and synthesizer joined by the link, driven over apb
`include "vcx_consts.svh"
module vcxo_divider_and_gain_planner_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import vcx_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam int TS = 12;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic clk_out;
	// mid supply, so tuning does not move the clock measured in test_plans; test_tune later raises it to full supply
	logic [11:0] vc_mv = 12'h0672;
	logic [31:0] rd;
	logic er;
	int error_cnt = 0;
	int checked = 0;
	int load_cnt = 0;
	vcx_feedback_divider_t snap_fb;
	logic [15:0] snap_kv;
	vcx_link_if vcx_link_if_inst ();
	vcx_planner_host #(.ADDR_W(8)) vcx_planner_host_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(vcx_link_if_inst.host));
	vcx_synth_dev #(.TICK_SHIFT(TS)) vcx_synth_dev_inst (.pclk(pclk), .presetn(presetn),
		.link(vcx_link_if_inst.dev), .control_voltage_input(vc_mv), .clk_out(clk_out));
	vcx_link_assertions vcx_link_assertions_inst (.pclk(pclk), .presetn(presetn),
		.load(vcx_link_if_inst.load), .feedback_divider(vcx_link_if_inst.feedback_divider),
		.high_speed_output_divider(vcx_link_if_inst.high_speed_output_divider),
		.low_speed_power2_divider(vcx_link_if_inst.low_speed_power2_divider),
		.vc_adc_full_scale_gain(vcx_link_if_inst.vc_adc_full_scale_gain),
		.tuning_gain_ppm_per_volt(vcx_link_if_inst.tuning_gain_ppm_per_volt),
		.load_ack(vcx_link_if_inst.load_ack));
	initial
	begin
		forever #5 pclk = ~pclk;
	end
	// settings are only valid in the load cycle, so capture them there
	always @(posedge pclk)
	begin
		if (vcx_link_if_inst.load === 1'b1)
		begin
			snap_fb <= vcx_link_if_inst.feedback_divider;
			snap_kv <= vcx_link_if_inst.tuning_gain_ppm_per_volt;
			load_cnt <= load_cnt + 1;
		end
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic hang();
		error_cnt++;
		$display("unexpected at %0t: wait ran out", $time);
		complete_run();
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll status until the plan reports done or fail
	task automatic wait_plan();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, `VCX_REG_STATUS, 32'h0000_0000);
			n++;
		end
		while (rd[2:1] === 2'b00 && n < 500);
		if (rd[2:1] === 2'b00)
			hang();
	endtask
	task automatic run_plan(input logic [31:0] fout, input logic [2:0] ctrl);
		apb(1'b1, `VCX_REG_FOUT, fout);
		apb(1'b1, `VCX_REG_CTRL, {29'h0, ctrl});
		wait_plan();
	endtask
	// half periods of clk_out against hs*ls half ticks of the modelled vco
	task automatic duty(input int p, input vcx_feedback_divider_t fb);
		real half;
		int hi;
		int lo;
		half = p * (2.0 ** (32 + TS)) / real'(fb);
		for (int k = 0; k < 2; k++)
		begin
			hi = 0;
			lo = 0;
			while (clk_out !== 1'b1 && lo < 9000)
			begin
				@(posedge pclk);
				lo++;
			end
			while (clk_out === 1'b1 && hi < 9000)
			begin
				@(posedge pclk);
				hi++;
			end
			lo = 0;
			while (clk_out === 1'b0 && lo < 9000)
			begin
				@(posedge pclk);
				lo++;
			end
			if (hi >= 9000 || lo >= 9000)
				hang();
		end
		check(hi > half - 2.5 && hi < half + 2.5, 1'b1);
		check(lo > half - 2.5 && lo < half + 2.5, 1'b1);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		apb(1'b0, `VCX_REG_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		check(vcx_link_if_inst.feedback_divider, `VCX_FB_RST);
		check(vcx_link_if_inst.high_speed_output_divider, `VCX_HS_RST);
		apb(1'b0, 8'h20, 32'h0000_0000);
		check({er, rd}, {1'b1, 32'h0000_0000});
		apb(1'b1, 8'h24, 32'h1234_5678);
		check(er, 1'b1);
		$display("test reset and unmapped done");
	endtask
	task automatic test_plans();
		logic [31:0] fo [4] = '{32'd156750000, 32'd2875000000, 32'd1000000, 32'd400000000};
		logic [2:0] ct [4] = '{3'h7, 3'h1, 3'h7, 3'h1};
		logic [31:0] hl [4] = '{32'h0000_0046, 32'h0000_0004, 32'h0000_3546, 32'h0000_001B};
		logic [42:0] fb [4] = '{43'h047_E756_E62A, 43'h04B_5C44_7213, 43'h046_C5F4_97A7,
			43'h046_C5F4_97A7};
		logic [31:0] gn [4] = '{32'h0000_1077, 32'h0000_1280, 32'h0000_1079, 32'h0000_1079};
		int c;
		for (int i = 0; i < 4; i++)
		begin
			c = load_cnt;
			apb(1'b1, `VCX_REG_KV, 32'h0000_0101 + i);
			run_plan(fo[i], ct[i]);
			check(rd[2:1], 2'b01);
			check(load_cnt, c + 1);
			check(snap_kv, 16'h0101 + i);
			check(snap_fb, fb[i]);
			apb(1'b0, `VCX_REG_HSLS, 32'h0000_0000);
			check(rd, hl[i]);
			apb(1'b0, `VCX_REG_FBLO, 32'h0000_0000);
			check(rd, fb[i][31:0]);
			apb(1'b0, `VCX_REG_FBHI, 32'h0000_0000);
			check(rd, {21'h0, fb[i][42:32]});
			apb(1'b0, `VCX_REG_GAIN, 32'h0000_0000);
			check(rd, gn[i]);
			if (i % 2 == 1)
				duty(hl[i], fb[i]);
		end
		$display("test plans done");
	endtask
	task automatic test_fail();
		// the last one passes the range check but lands above the fastest vco maximum
		logic [31:0] fo [5] = '{32'd199999, 32'd1500000001, 32'd800000001, 32'd325000001,
			32'd2640000000};
		int c;
		for (int i = 0; i < 5; i++)
		begin
			c = load_cnt;
			run_plan(fo[i], {i[1:0], 1'b1});
			check(rd[2:1], 2'b10);
			check(load_cnt, c);
		end
		$display("test refusals done");
	endtask
	// full supply on the control pin with a strong gain must speed up the output clock
	task automatic test_tune();
		vcx_feedback_divider_t fbt;
		real r;
		vc_mv <= 12'hCE4;
		apb(1'b1, `VCX_REG_KV, 32'h0000_FFFF);
		apb(1'b1, `VCX_REG_FOUT, 32'd400000000);
		apb(1'b1, `VCX_REG_CTRL, 32'h0000_0001);
		// writes and a second start while busy must be dropped
		apb(1'b1, `VCX_REG_FOUT, 32'd1000000);
		apb(1'b1, `VCX_REG_KV, 32'h0000_0000);
		apb(1'b1, `VCX_REG_CTRL, 32'h0000_0007);
		wait_plan();
		check(rd[2:1], 2'b01);
		apb(1'b0, `VCX_REG_FOUT, 32'h0000_0000);
		check(rd, 32'd400000000);
		apb(1'b0, `VCX_REG_KV, 32'h0000_0000);
		check(rd, 32'h0000_FFFF);
		apb(1'b0, `VCX_REG_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, `VCX_REG_HSLS, 32'h0000_0000);
		check(rd, 32'h0000_001B);
		check(snap_kv, 16'hFFFF);
		// let the control voltage adc take the new level and the tuning settle
		repeat (16000) @(posedge pclk);
		r = real'(43'h046_C5F4_97A7) * (1.0 + 1650.0 * 121.0 / 128.0 * 65535.0e-9);
		fbt = 43'(longint'(r));
		duty(27, fbt);
		$display("test tuning done");
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_plans();
		test_fail();
		test_tune();
		complete_run();
	end
endmodule // vcxo_divider_and_gain_planner_tb_top
